/* hdl/fdg_pkg.sv */
package fdg_pkg;

   // Clock rate and host-loss timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned LOSS_TIME_MS = 1000;
   localparam int unsigned LOSS_CYCLES_DFLT = int'((64'(LOSS_TIME_MS) * 64'(CLK_HZ)) / 64'd1000);

   // Switch settle cycles after reset release, before the one-time capture
   localparam logic [1:0] CFG_SETTLE_CYCLES = 2'h2;

   // Word map, offsets from the first control word
   localparam logic [11:0] MAP_CTRL_BASE = 12'h000;
   localparam logic [11:0] CTRL_WORDS = 12'h00A;
   localparam logic [11:0] MAP_PUB_BASE = 12'h00A;
   localparam logic [11:0] MAP_PUB_END = 12'h014;
   localparam logic [11:0] MAP_PARAM_BASE = 12'h064;
   localparam int unsigned MAP_WORDS = 20;
   localparam logic [10:0] PARAM_MAX = 11'h7D0;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // Host transfer types
   localparam logic [3:0] XFER_WRITE = 4'h1;
   localparam logic [3:0] XFER_READ = 4'h2;
   localparam logic [3:0] XFER_GWRITE = 4'h5;
   localparam logic [3:0] XFER_GREAD = 4'h6;

   // Slave group of sixteen in one host database: low four address bits
   localparam int unsigned GROUP_BITS = 4;

   // Wishbone word indices (byte address is four times the index)
   localparam logic [9:0] WB_IDX_MAP_END = 10'h014;
   localparam logic [9:0] WB_IDX_STATUS = 10'h020;

   // Switch bit positions
   localparam int unsigned SW_ADDR_LSB = 0;
   localparam int unsigned SW_LINK_LO = 6;
   localparam int unsigned SW_LINK_HI = 7;
   localparam int unsigned SW_GLOBAL = 6;
   localparam int unsigned SW_FAULT = 7;

   // Cyclic link selection and published word counts
   localparam logic [1:0] LINKS_NONE = 2'b00;
   localparam logic [1:0] LINKS_A = 2'b01;
   localparam logic [1:0] LINKS_AB = 2'b10;
   localparam logic [1:0] LINKS_ABCD = 2'b11;
   localparam logic [3:0] PUB_NONE = 4'h2;
   localparam logic [3:0] PUB_A = 4'h4;
   localparam logic [3:0] PUB_AB = 4'h6;
   localparam logic [3:0] PUB_ABCD = 4'hA;

   typedef struct packed {
      logic [5:0] slave_code;
      logic [5:0] host_code;
      logic global_ctl;
      logic fault_on_loss;
      logic [1:0] links;
   } fdg_cfg_t;

   typedef struct packed {
      logic [3:0] xfer;
      logic [11:0] addr;
      logic [15:0] data;
      logic [6:0] src;
   } fdg_hreq_t;

   typedef struct packed {
      logic [15:0] data;
      logic err;
   } fdg_hrsp_t;

   typedef struct packed {
      logic write;
      logic count_query;
      logic [10:0] idx;
      logic [15:0] data;
   } fdg_dreq_t;

   // Published word count for a link selection
   function automatic logic [3:0] fdg_pub_words(input logic [1:0] links);
      logic [3:0] n;
      n = PUB_NONE;
      case (links)
         LINKS_A: n = PUB_A;
         LINKS_AB: n = PUB_AB;
         LINKS_ABCD: n = PUB_ABCD;
         default: n = PUB_NONE;
      endcase
      return n;
   endfunction

endpackage

/* hdl/fdg_cfg_capture.sv */
`timescale 1ns/1ps
module fdg_cfg_capture import fdg_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Switch pins
   input wire logic [7:0] bank1_i,
   input wire logic [7:0] bank2_i,
   // Captured settings
   output fdg_cfg_t cfg_o,
   output logic valid_o
);

   logic [15:0] sync1;
   logic [15:0] sync2;
   logic [1:0] cnt;
   fdg_cfg_t cfg;
   logic valid;
   logic [15:0] next_sync1;
   logic [15:0] next_sync2;
   logic [1:0] next_cnt;
   fdg_cfg_t next_cfg;
   logic next_valid;

   // Capture once after settle; later switch moves are ignored until reset
   always_comb begin
      next_sync1 = {bank2_i, bank1_i};
      next_sync2 = sync1;
      next_cnt = cnt;
      next_cfg = cfg;
      next_valid = valid;
      if (!valid) begin
         if (cnt == CFG_SETTLE_CYCLES) begin
            next_cfg.host_code = sync2[SW_ADDR_LSB +: 6];
            next_cfg.links = {sync2[SW_LINK_HI], sync2[SW_LINK_LO]};
            next_cfg.slave_code = sync2[8 + SW_ADDR_LSB +: 6];
            next_cfg.global_ctl = sync2[8 + SW_GLOBAL];
            next_cfg.fault_on_loss = sync2[8 + SW_FAULT];
            next_valid = 1'b1;
         end else begin
            next_cnt = cnt + 2'h1;
         end
      end
   end

   // Register stage; sync1 feeds only sync2
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 16'h0000;
         sync2 <= 16'h0000;
         cnt <= 2'h0;
         cfg <= '0;
         valid <= 1'b0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         cnt <= next_cnt;
         cfg <= next_cfg;
         valid <= next_valid;
      end
   end

   assign cfg_o = cfg;
   assign valid_o = valid;

endmodule

/* hdl/fdg_loss_timer.sv */
`timescale 1ns/1ps
module fdg_loss_timer #(
   parameter int unsigned CYCLES = 40_000_000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Host activity and loss flag
   input wire logic kick_i,
   output logic lost_o
);

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt;
   logic armed;
   logic lost;
   logic [CW-1:0] next_cnt;
   logic next_armed;
   logic next_lost;

   // Armed by first host contact, so a silent bus at start is not a loss
   always_comb begin
      next_cnt = cnt;
      next_armed = armed;
      next_lost = lost;
      if (kick_i) begin
         next_cnt = '0;
         next_armed = 1'b1;
         next_lost = 1'b0;
      end else if (armed && !lost) begin
         if (cnt == CW'(CYCLES - 1)) begin
            next_lost = 1'b1;
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end
   end

   // Register stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
         armed <= 1'b0;
         lost <= 1'b0;
      end else begin
         cnt <= next_cnt;
         armed <= next_armed;
         lost <= next_lost;
      end
   end

   assign lost_o = lost;

endmodule

/* hdl/fdg_gateway.sv */
// What this block does
// - Directed read returns current contents of any addressed map word.
// - Publish two to ten words, read by global-data read.
// - Directed write accepted on control words and parameters below the limit; parameter writes forwarded to the drive.
// - Directed writes to control words only while global control disabled.
// - With global control, control words come from selected host's table.
// - Poll drive parameter count at start, cap list at 2000.
// - Words 11 to 20 all published only with links A to D (words 11 and 12 with none); all readable by directed read.
// - Switches sampled only at start; later changes ignored until reset.
// - Settings: slave, host address, global, fault-on-loss, link choice.
// - Control and parameters read/write; status and inbound words read-only.
// - Global mode serves any slave slot in a group of sixteen.
// - Two link switches select none, A, A and B, or A to D.
`timescale 1ns/1ps
module fdg_gateway import fdg_pkg::*; #(
   parameter int unsigned LOSS_CYCLES = LOSS_CYCLES_DFLT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Configuration switches
   input wire logic [7:0] first_config_switch_bank_i,
   input wire logic [7:0] second_config_switch_bank_i,
   // Host network transfer block port
   input wire logic hreq_valid_i,
   input fdg_hreq_t hreq_i,
   output logic hreq_ready_o,
   output logic hrsp_valid_o,
   output fdg_hrsp_t hrsp_o,
   // Drive link
   output logic dreq_valid_o,
   output fdg_dreq_t dreq_o,
   input wire logic dreq_ready_i,
   input wire logic drsp_valid_i,
   input wire logic [15:0] drsp_data_i,
   // Status
   output logic drive_fault_o,
   output logic host_lost_o
);

   typedef enum logic [1:0] {S_INIT, S_POLL, S_IDLE, S_DRV} fdg_state_t;

   fdg_state_t state, next_state;
   logic [15:0] words [MAP_WORDS];
   logic [15:0] next_words [MAP_WORDS];
   fdg_hrsp_t hrsp, next_hrsp;
   logic hrsp_valid, next_hrsp_valid;
   fdg_dreq_t dreq, next_dreq;
   logic dreq_valid, next_dreq_valid;
   logic [10:0] param_limit, next_param_limit;
   logic ack, next_ack;
   logic [31:0] wb_dat, next_wb_dat;
   logic fault, next_fault;
   fdg_cfg_t cfg;
   logic cfg_valid;
   logic lost;
   logic take;
   logic [3:0] pub_count;
   logic [11:0] slot_base;
   logic [11:0] gw_off;
   logic gw_hit;
   logic [9:0] wb_idx;
   logic [11:0] param_off;
   logic [15:0] word_at_req;
   logic [6:0] host_addr;

   // One-time switch capture
   fdg_cfg_capture u_cfg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bank1_i(first_config_switch_bank_i),
      .bank2_i(second_config_switch_bank_i),
      .cfg_o(cfg),
      .valid_o(cfg_valid)
   );

   // Host silence watchdog, kicked by every accepted transfer
   fdg_loss_timer #(.CYCLES(LOSS_CYCLES)) u_loss (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .kick_i(take),
      .lost_o(lost)
   );

   // Request decode helpers
   assign take = hreq_valid_i && (state == S_IDLE);
   assign hreq_ready_o = (state == S_IDLE);
   assign pub_count = fdg_pub_words(cfg.links);
   assign slot_base = 12'(12'(cfg.slave_code[GROUP_BITS-1:0]) * CTRL_WORDS);
   assign gw_off = hreq_i.addr - slot_base;
   assign host_addr = 7'(cfg.host_code) + 7'h01;
   // only the selected host's table, only in global mode
   assign gw_hit = cfg.global_ctl && (hreq_i.src == host_addr) && (hreq_i.addr >= slot_base) && (gw_off < CTRL_WORDS);
   assign param_off = hreq_i.addr - MAP_PARAM_BASE;
   assign wb_idx = wb_adr_i[11:2];
   assign word_at_req = (hreq_i.addr < MAP_PUB_END) ? words[hreq_i.addr[4:0]] : WORD_RESET;

   // Next-state logic for bus, host and drive sides
   always_comb begin
      next_state = state;
      next_words = words;
      next_hrsp = hrsp;
      next_hrsp_valid = 1'b0;
      next_dreq = dreq;
      next_dreq_valid = dreq_valid;
      next_param_limit = param_limit;
      next_ack = 1'b0;
      next_wb_dat = wb_dat;
      // fault only when enabled; words are never cleared on loss
      next_fault = lost && cfg.fault_on_loss;
      // Wishbone: one wait state, ack dropped the cycle after it is given
      if (wb_cyc_i && wb_stb_i && !ack) begin
         next_ack = 1'b1;
         next_wb_dat = 32'h00000000;
         if (wb_idx < WB_IDX_MAP_END) begin
            next_wb_dat = {16'h0000, words[wb_idx[4:0]]};
            // Firmware fills status and inbound words only
            if (wb_we_i && (wb_idx >= 10'(MAP_PUB_BASE)) && (wb_sel_i[1:0] == 2'b11)) begin
               next_words[wb_idx[4:0]] = wb_dat_i[15:0];
            end
         end else if (wb_idx == WB_IDX_STATUS) begin
            next_wb_dat = {3'h0, lost, cfg_valid, cfg, param_limit};
         end
      end
      // Drive request handshake
      if (dreq_valid && dreq_ready_i) begin
         next_dreq_valid = 1'b0;
      end
      case (state)
         S_INIT: begin
            if (cfg_valid) begin
               next_dreq = '{write: 1'b0, count_query: 1'b1, idx: 11'h000, data: 16'h0000};
               next_dreq_valid = 1'b1;
               next_state = S_POLL;
            end
         end
         S_POLL: begin
            if (!dreq_valid && drsp_valid_i) begin
               if (drsp_data_i > 16'(PARAM_MAX)) begin
                  next_param_limit = PARAM_MAX;
               end else begin
                  next_param_limit = drsp_data_i[10:0];
               end
               next_state = S_IDLE;
            end
         end
         S_IDLE: begin
            if (take) begin
               next_hrsp = '{data: 16'h0000, err: 1'b0};
               next_hrsp_valid = 1'b1;
               case (hreq_i.xfer)
                  XFER_READ: begin
                     if (hreq_i.addr < MAP_PARAM_BASE) begin
                        next_hrsp.data = word_at_req;
                     end else if (param_off < 12'(param_limit)) begin
                        next_hrsp_valid = 1'b0;
                        next_dreq = '{write: 1'b0, count_query: 1'b0, idx: param_off[10:0], data: 16'h0000};
                        next_dreq_valid = 1'b1;
                        next_state = S_DRV;
                     end else begin
                        next_hrsp.err = 1'b1;
                     end
                  end
                  XFER_WRITE: begin
                     if (hreq_i.addr < CTRL_WORDS) begin
                        // protect control words in global mode
                        if (cfg.global_ctl) begin
                           next_hrsp.err = 1'b1;
                        end else begin
                           next_words[hreq_i.addr[4:0]] = hreq_i.data;
                        end
                     end else if (hreq_i.addr < MAP_PARAM_BASE) begin
                        next_hrsp.err = 1'b1;
                     end else if (param_off < 12'(param_limit)) begin
                        next_hrsp_valid = 1'b0;
                        next_dreq = '{write: 1'b1, count_query: 1'b0, idx: param_off[10:0], data: hreq_i.data};
                        next_dreq_valid = 1'b1;
                        next_state = S_DRV;
                     end else begin
                        next_hrsp.err = 1'b1;
                     end
                  end
                  XFER_GREAD: begin
                     if (hreq_i.addr < 12'(pub_count)) begin
                        next_hrsp.data = words[5'(MAP_PUB_BASE) + hreq_i.addr[4:0]];
                     end else begin
                        next_hrsp.err = 1'b1;
                     end
                  end
                  XFER_GWRITE: begin
                     // take control words from host table
                     if (gw_hit) begin
                        next_words[gw_off[4:0]] = hreq_i.data;
                     end
                  end
                  default: begin
                     next_hrsp.err = 1'b1;
                  end
               endcase
            end
         end
         S_DRV: begin
            if (!dreq_valid && drsp_valid_i) begin
               next_hrsp = '{data: drsp_data_i, err: 1'b0};
               next_hrsp_valid = 1'b1;
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_INIT;
         end
      endcase
   end

   // Register stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_INIT;
         for (int i = 0; i < MAP_WORDS; i++) begin
            words[i] <= WORD_RESET;
         end
         hrsp <= '0;
         hrsp_valid <= 1'b0;
         dreq <= '0;
         dreq_valid <= 1'b0;
         param_limit <= 11'h000;
         ack <= 1'b0;
         wb_dat <= 32'h00000000;
         fault <= 1'b0;
      end else begin
         state <= next_state;
         words <= next_words;
         hrsp <= next_hrsp;
         hrsp_valid <= next_hrsp_valid;
         dreq <= next_dreq;
         dreq_valid <= next_dreq_valid;
         param_limit <= next_param_limit;
         ack <= next_ack;
         wb_dat <= next_wb_dat;
         fault <= next_fault;
      end
   end

   // Outputs
   assign wb_ack_o = ack;
   assign wb_dat_o = wb_dat;
   assign hrsp_valid_o = hrsp_valid;
   assign hrsp_o = hrsp;
   assign dreq_valid_o = dreq_valid;
   assign dreq_o = dreq;
   assign drive_fault_o = fault;
   assign host_lost_o = lost;

   // Read answers carry the word present at the request
   property p_dir_read;
      @(posedge clk_i) disable iff (rst_i)
      take && (hreq_i.xfer == XFER_READ) && (hreq_i.addr < MAP_PUB_END)
      |=> hrsp_valid_o && !hrsp_o.err && (hrsp_o.data == $past(word_at_req));
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("directed read data wrong");

   property p_gread_range;
      @(posedge clk_i) disable iff (rst_i)
      take && (hreq_i.xfer == XFER_GREAD) && (hreq_i.addr >= 12'(pub_count)) |=> hrsp_valid_o && hrsp_o.err;
   endproperty
   a_gread_range: assert property (p_gread_range) else $error("global read past published count");

   property p_fwd_write;
      @(posedge clk_i) disable iff (rst_i)
      take && (hreq_i.xfer == XFER_WRITE) && (hreq_i.addr >= MAP_PARAM_BASE) && (param_off < 12'(param_limit))
      |=> dreq_valid_o && dreq_o.write && !hrsp_valid_o && (dreq_o.data == $past(hreq_i.data));
   endproperty
   a_fwd_write: assert property (p_fwd_write) else $error("parameter write not forwarded");

   property p_ctrl_protect;
      @(posedge clk_i) disable iff (rst_i)
      take && cfg.global_ctl && (hreq_i.xfer == XFER_WRITE) && (hreq_i.addr < CTRL_WORDS)
      |=> hrsp_o.err && (words[$past(hreq_i.addr[4:0])] == $past(word_at_req));
   endproperty
   a_ctrl_protect: assert property (p_ctrl_protect) else $error("control word not protected");

   property p_gwrite;
      @(posedge clk_i) disable iff (rst_i)
      take && (hreq_i.xfer == XFER_GWRITE) && gw_hit |=> words[$past(gw_off[4:0])] == $past(hreq_i.data);
   endproperty
   a_gwrite: assert property (p_gwrite) else $error("global table not applied");

   property p_poll;
      @(posedge clk_i) disable iff (rst_i)
      (state == S_INIT) && cfg_valid |=> dreq_valid_o && dreq_o.count_query ##1 (param_limit <= PARAM_MAX) [*2];
   endproperty
   a_poll: assert property (p_poll) else $error("count poll missing");

   property p_cfg_hold;
      @(posedge clk_i) disable iff (rst_i)
      cfg_valid && $past(cfg_valid) |-> $stable(cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed while running");

   property p_pub_ro;
      @(posedge clk_i) disable iff (rst_i)
      take && (hreq_i.xfer == XFER_WRITE) && (hreq_i.addr >= MAP_PUB_BASE) && (hreq_i.addr < MAP_PUB_END)
      |=> hrsp_o.err;
   endproperty
   a_pub_ro: assert property (p_pub_ro) else $error("read-only word accepted write");

   property p_links;
      @(posedge clk_i) disable iff (rst_i)
      cfg_valid |-> (cfg.links == LINKS_ABCD) == (pub_count == PUB_ABCD);
   endproperty
   a_links: assert property (p_links) else $error("link selection decode wrong");

   property p_fault;
      @(posedge clk_i) disable iff (rst_i)
      lost && cfg.fault_on_loss |=> drive_fault_o;
   endproperty
   a_fault: assert property (p_fault) else $error("loss fault not raised");

endmodule

/* dv/fdg_drive_model.sv */
`timescale 1ns/1ps
module fdg_drive_model import fdg_pkg::*; #(
   parameter logic [15:0] PARAM_COUNT = 16'h09C4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request side
   input wire logic dreq_valid_i,
   input fdg_dreq_t dreq_i,
   output logic dreq_ready_o,
   input wire logic slow_i,
   // Answer side
   output logic drsp_valid_o,
   output logic [15:0] drsp_data_o
);
   logic [15:0] mem [16];
   fdg_dreq_t req;
   logic busy;
   logic [3:0] cnt;

   // One answer per request; idle data toggles so a stale word never looks fresh
   always @(posedge clk_i) begin
      drsp_valid_o <= 1'b0;
      drsp_data_o <= ~drsp_data_o;
      if (rst_i) begin
         busy <= 1'b0;
         dreq_ready_o <= 1'b0;
         cnt <= 4'h0;
         drsp_data_o <= 16'h0000;
         for (int i = 0; i < 16; i++) begin
            mem[i] <= 16'h0000;
         end
      end else if (dreq_valid_i && dreq_ready_o) begin
         busy <= 1'b1;
         dreq_ready_o <= 1'b0;
         req <= dreq_i;
         cnt <= slow_i ? 4'h9 : 4'h1;
      end else if (busy) begin
         if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else begin
            busy <= 1'b0;
            drsp_valid_o <= 1'b1;
            if (req.count_query) begin
               drsp_data_o <= PARAM_COUNT;
            end else if (req.write) begin
               mem[req.idx[3:0]] <= req.data;
               drsp_data_o <= req.data;
            end else begin
               drsp_data_o <= mem[req.idx[3:0]];
            end
         end
      end else begin
         dreq_ready_o <= 1'b1;
      end
   end
endmodule

/* dv/fdg_gateway_tb.sv */
`timescale 1ns/1ps
module fdg_gateway_tb;
   import fdg_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] q;
   logic [7:0] bank1 = 8'h00;
   logic [7:0] bank2 = 8'h00;
   logic hreq_valid_i = 1'b0;
   logic slow = 1'b0;
   logic wb_ack_o, hreq_ready_o, hrsp_valid_o, dreq_valid_o, dreq_ready_i, drsp_valid_i;
   logic drive_fault_o, host_lost_o, er;
   fdg_hreq_t hreq_i = '0;
   fdg_hrsp_t hrsp_o;
   fdg_dreq_t dreq_o;
   logic [15:0] drsp_data_i, rd;
   int error_cnt = 0;
   int checks_done = 0;

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   fdg_gateway #(.LOSS_CYCLES(50)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .first_config_switch_bank_i(bank1), .second_config_switch_bank_i(bank2),
      .hreq_valid_i(hreq_valid_i), .hreq_i(hreq_i), .hreq_ready_o(hreq_ready_o),
      .hrsp_valid_o(hrsp_valid_o), .hrsp_o(hrsp_o), .dreq_valid_o(dreq_valid_o), .dreq_o(dreq_o),
      .dreq_ready_i(dreq_ready_i), .drsp_valid_i(drsp_valid_i), .drsp_data_i(drsp_data_i),
      .drive_fault_o(drive_fault_o), .host_lost_o(host_lost_o));

   fdg_drive_model drv_u (.clk_i(clk_i), .rst_i(rst_i), .dreq_valid_i(dreq_valid_o), .dreq_i(dreq_o),
      .dreq_ready_o(dreq_ready_i), .slow_i(slow), .drsp_valid_o(drsp_valid_i), .drsp_data_o(drsp_data_i));

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tmo;
      error_cnt++;
      $display("wrong value at %0t: no answer in time", $time);
      finish_test();
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) tmo();
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Host request held until taken, then wait for the answer pulse
   task automatic host(input logic [3:0] x, input logic [11:0] a, input logic [15:0] d, input logic [6:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      hreq_valid_i <= 1'b1;
      hreq_i <= '{xfer: x, addr: a, data: d, src: s};
      do begin
         @(posedge clk_i);
         n++;
      end while (hreq_ready_o !== 1'b1 && n < 100);
      hreq_valid_i <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hrsp_valid_o !== 1'b1 && n < 200);
      if (hrsp_valid_o !== 1'b1) tmo();
      rd = hrsp_o.data;
      er = hrsp_o.err;
   endtask

   task automatic hx(input logic [3:0] x, input logic [11:0] a, input logic [15:0] d, input logic e);
      host(x, a, d, 7'h03);
      chk({31'h0, er}, {31'h0, e});
   endtask

   // Power cycle with new switch settings
   task automatic pwr(input logic [7:0] b1, input logic [7:0] b2);
      int n;
      n = 0;
      @(posedge clk_i);
      rst_i <= 1'b1;
      bank1 <= b1;
      bank2 <= b2;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hreq_ready_o !== 1'b1 && n < 100);
      if (hreq_ready_o !== 1'b1) tmo();
   endtask

   initial begin
      #500000;
      tmo();
   end

   initial begin
      // All links, host code 2, slave code 5, global and fault off
      pwr(8'hC2, 8'h05);
      wb(1'b0, 10'h020, 32'h0);
      chk(q & 32'h7FF, 32'h7D0);
      wb(1'b0, 10'h030, 32'h0);
      chk(q, 32'h0);
      // Live switch change must not matter
      @(posedge clk_i);
      bank2 <= 8'hC5;
      hx(XFER_WRITE, 12'h003, 16'h1234, 1'b0);
      host(XFER_READ, 12'h003, 16'h0, 7'h03);
      chk(rd, 16'h1234);
      wb(1'b0, 10'h003, 32'h0);
      chk(q & 32'hFFFF, 32'h1234);
      wb(1'b1, 10'h00C, 32'hBEEF);
      host(XFER_GREAD, 12'h002, 16'h0, 7'h03);
      chk(rd, 16'hBEEF);
      host(XFER_READ, 12'h00C, 16'h0, 7'h03);
      chk(rd, 16'hBEEF);
      hx(XFER_WRITE, 12'h00C, 16'h0001, 1'b1);
      hx(XFER_GREAD, 12'h009, 16'h0, 1'b0);
      hx(XFER_GREAD, 12'h00A, 16'h0, 1'b1);
      slow <= 1'b1;
      hx(XFER_WRITE, 12'h069, 16'hC0DE, 1'b0);
      slow <= 1'b0;
      host(XFER_READ, 12'h069, 16'h0, 7'h03);
      chk(rd, 16'hC0DE);
      hx(XFER_READ, 12'h833, 16'h0, 1'b0);
      hx(XFER_READ, 12'h834, 16'h0, 1'b1);
      hx(4'h3, 12'h000, 16'h0, 1'b1);
      repeat (60) @(posedge clk_i);
      chk({30'h0, host_lost_o, drive_fault_o}, 32'h2);
      host(XFER_READ, 12'h003, 16'h0, 7'h03);
      chk(rd, 16'h1234);
      $display("test plain mode done");
      // Link A only, global control and fault on loss
      pwr(8'h42, 8'hC5);
      hx(XFER_WRITE, 12'h003, 16'h1111, 1'b1);
      hx(XFER_GWRITE, 12'h035, 16'h5A5A, 1'b0);
      host(XFER_READ, 12'h003, 16'h0, 7'h03);
      chk(rd, 16'h5A5A);
      host(XFER_GWRITE, 12'h035, 16'h6B6B, 7'h04);
      host(XFER_READ, 12'h003, 16'h0, 7'h03);
      chk(rd, 16'h5A5A);
      hx(XFER_GREAD, 12'h003, 16'h0, 1'b0);
      hx(XFER_GREAD, 12'h004, 16'h0, 1'b1);
      repeat (60) @(posedge clk_i);
      chk({31'h0, drive_fault_o}, 32'h1);
      wb(1'b0, 10'h020, 32'h0);
      chk(q & 32'h1000_0000, 32'h1000_0000);
      $display("test global mode done");
      finish_test();
   end
endmodule
